// [cti_cell.sv]
// One unit under test: selector, majority, latch or flop
`timescale 1ns/1ps
module cti_cell
	import cti_pkg::*;
#(
	parameter int CELL_KIND = 0
)(
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_a,
	input  wire logic i_b,
	input  wire logic i_c,
	output logic      o_y
);
	logic state_reg;
	logic state_next;
	logic a_prev_reg;

	always_comb begin
		state_next = state_reg;
		if (!i_c) begin
			state_next = 1'b0;
		end else if (CELL_KIND == CTI_KIND_LATCH && i_a) begin
			state_next = i_b;
		end else if (CELL_KIND == CTI_KIND_FLOP && i_a && !a_prev_reg) begin
			state_next = i_b;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg  <= 1'b0;
			a_prev_reg <= 1'b0;
		end else begin
			state_reg  <= state_next;
			a_prev_reg <= i_a;
		end
	end

	always_comb begin
		case (CELL_KIND)
			CTI_KIND_SELECTOR: o_y = ~(i_c ? i_b : i_a);
			CTI_KIND_MAJORITY: o_y = (i_a & i_b) | (i_a & i_c) | (i_b & i_c);
			CTI_KIND_LATCH:    o_y = !i_c ? 1'b0 : (i_a ? i_b : state_reg);
			default:           o_y = !i_c ? 1'b0 : state_reg;
		endcase
	end
endmodule // cti_cell

// [cti_pkg.sv]
// Shared constants for the cell test instrumentation block
package cti_pkg;
	// ----------------------------------------------------------------
	// Structure sizes
	// ----------------------------------------------------------------
	localparam int CTI_COPIES     = 8;
	localparam int CTI_STIM_SETS  = 12;
	localparam int CTI_STIM_BITS  = 3;
	localparam int CTI_STIM_W     = CTI_STIM_SETS * CTI_STIM_BITS;
	localparam int CTI_RES_BITS   = 44;
	localparam int CTI_PIPE_TICKS = CTI_STIM_SETS + CTI_RES_BITS;
	localparam int CTI_DIV_BITS   = 3;
	localparam int CTI_PRESC_W    = 7;

	// ----------------------------------------------------------------
	// Cell kinds, one per output pair
	// ----------------------------------------------------------------
	localparam int CTI_KIND_SELECTOR = 0;
	localparam int CTI_KIND_MAJORITY = 1;
	localparam int CTI_KIND_LATCH    = 2;
	localparam int CTI_KIND_FLOP     = 3;

	// ----------------------------------------------------------------
	// Register map (word indices on the bus, field bit positions)
	// ----------------------------------------------------------------
	localparam int          CTI_ADDR_W     = 4;
	localparam logic [3:0]  CTI_IDX_CTRL   = 4'h0;
	localparam logic [3:0]  CTI_IDX_STATUS = 4'h1;
	localparam int          CTI_CTRL_OSC   = 0;
	localparam logic [31:0] CTI_CTRL_RESET = 32'h00000001;
	localparam int          CTI_ST_DIRECT  = 0;
	localparam int          CTI_ST_INSTR   = 8;
	localparam int          CTI_ST_MODE    = 16;
endpackage

// [cti_tester.sv]
// Bench tester driving stimulus, mode, trigger and divider pins
`timescale 1ns/1ps
module cti_tester (
	input  wire logic       i_clk,
	output logic      [2:0] o_stim,
	output logic            o_mode,
	output logic            o_trigger,
	output logic      [2:0] o_div
);
	initial begin
		o_stim = 3'h0;
		o_mode = 1'b0;
		o_trigger = 1'b0;
		o_div = 3'h0;
	end
	// Pins change only while trigger is low
	task automatic setup(input logic [2:0] s, input logic m, input logic [2:0] d);
		@(posedge i_clk);
		o_stim <= s;
		o_mode <= m;
		o_div <= d;
	endtask
	task automatic pulse(input int hi);
		@(posedge i_clk);
		o_trigger <= 1'b1;
		repeat (hi) @(posedge i_clk);
		o_trigger <= 1'b0;
		repeat (3) @(posedge i_clk);
	endtask
endmodule // cti_tester

// [cti_top.sv]
// Cell test instrumentation: direct and shift-register test paths
//
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module cti_top
	import cti_pkg::*;
(
	input  wire logic                  i_clk,
	input  wire logic                  i_resetn,
	input  wire logic [2:0]            i_stim,
	input  wire logic                  i_mode,
	input  wire logic                  i_trigger,
	input  wire logic [2:0]            i_div,
	input  wire logic [CTI_ADDR_W-1:0] i_avs_address,
	input  wire logic                  i_avs_read,
	input  wire logic                  i_avs_write,
	input  wire logic [31:0]           i_avs_writedata,
	output logic      [31:0]           o_avs_readdata,
	output logic                       o_avs_waitrequest,
	output logic      [7:0]            o_direct,
	output logic      [7:0]            o_bidir_out,
	output logic      [7:0]            o_bidir_oe
);
	// ----------------------------------------------------------------
	// Reset synchroniser
	// ----------------------------------------------------------------
	logic rst_meta_reg;
	logic rst_n;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	logic [31:0] ctrl_reg;
	logic [31:0] ctrl_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic        ack_reg;
	logic        ack_next;
	logic [31:0] status_word;

	always_comb begin
		ctrl_next  = ctrl_reg;
		rdata_next = rdata_reg;
		ack_next   = 1'b0;
		// Write lands on the edge that completes the transfer
		if (i_avs_write && ack_reg && i_avs_address == CTI_IDX_CTRL) begin
			ctrl_next = i_avs_writedata & CTI_CTRL_RESET;
		end
		if ((i_avs_read || i_avs_write) && !ack_reg) begin
			ack_next = 1'b1;
			if (i_avs_read) begin
				case (i_avs_address)
					CTI_IDX_CTRL:   rdata_next = ctrl_reg;
					CTI_IDX_STATUS: rdata_next = status_word;
					default:        rdata_next = 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg  <= CTI_CTRL_RESET;
			rdata_reg <= 32'h00000000;
			ack_reg   <= 1'b0;
		end else begin
			ctrl_reg  <= ctrl_next;
			rdata_reg <= rdata_next;
			ack_reg   <= ack_next;
		end
	end

	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_reg;
	assign o_avs_readdata    = rdata_reg;

	// ----------------------------------------------------------------
	// Oscillator prescaler and clock switch
	// ----------------------------------------------------------------
	logic [CTI_PRESC_W-1:0] presc_reg;
	logic [CTI_PRESC_W-1:0] presc_next;
	logic [CTI_PRESC_W-1:0] presc_mask;
	logic                   osc_run;
	logic                   div_tick;
	logic                   trig_prev_reg;
	logic                   trig_rise;
	logic                   shift_en;

	assign osc_run    = ctrl_reg[CTI_CTRL_OSC];
	assign presc_mask = CTI_PRESC_W'((8'h01 << i_div) - 8'h01);
	assign div_tick   = osc_run && ((presc_reg & presc_mask) == presc_mask);
	assign trig_rise  = i_trigger && !trig_prev_reg;
	// Shared switch feeding every copy
	assign shift_en   = i_mode ? (i_trigger && div_tick) : trig_rise;

	always_comb begin
		presc_next = osc_run ? presc_reg + CTI_PRESC_W'(1) : presc_reg;
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			presc_reg     <= '0;
			trig_prev_reg <= 1'b0;
		end else begin
			presc_reg     <= presc_next;
			trig_prev_reg <= i_trigger;
		end
	end

	// ----------------------------------------------------------------
	// Stimulus shift register and trigger delay chain
	// ----------------------------------------------------------------
	logic [CTI_STIM_W-1:0]   stim_reg;
	logic [CTI_STIM_W-1:0]   stim_next;
	logic [CTI_RES_BITS:0]   chain_reg;
	logic [CTI_RES_BITS:0]   chain_next;
	logic [CTI_RES_BITS-1:0] tap_rise;
	logic [2:0]              stim_tail;

	always_comb begin
		stim_next  = shift_en ? {stim_reg[CTI_STIM_W-4:0], i_stim} : stim_reg;
		chain_next = i_mode ? {chain_reg[CTI_RES_BITS-1:0], i_trigger} : '0;
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			stim_reg  <= '0;
			chain_reg <= '0;
		end else begin
			stim_reg  <= stim_next;
			chain_reg <= chain_next;
		end
	end

	assign stim_tail = stim_reg[CTI_STIM_W-1 -: CTI_STIM_BITS];
	// Tap k rose when it is high now and was low last cycle
	assign tap_rise  = chain_reg[CTI_RES_BITS-1:0] & ~chain_reg[CTI_RES_BITS:1];

	// ----------------------------------------------------------------
	// Eight test copies
	// ----------------------------------------------------------------
	logic [7:0] instr_out;

	genvar gi;
	generate
		for (gi = 0; gi < CTI_COPIES; gi++) begin : g_copy
			logic                    cell_y;
			logic [CTI_RES_BITS-1:0] res_reg;
			logic [CTI_RES_BITS-1:0] res_next;

			// Direct copy, fed straight from the pins; only latch and flop cells hold state
			cti_cell #(.CELL_KIND(gi / 2)) u_direct (
				.i_clk   (i_clk),
				.i_rst_n (rst_n),
				.i_a     (i_stim[0]),
				.i_b     (i_stim[1]),
				.i_c     (i_stim[2]),
				.o_y     (o_direct[gi])
			);

			cti_cell #(.CELL_KIND(gi / 2)) u_instr (
				.i_clk   (i_clk),
				.i_rst_n (rst_n),
				.i_a     (stim_tail[0]),
				.i_b     (stim_tail[1]),
				.i_c     (stim_tail[2]),
				.o_y     (cell_y)
			);

			always_comb begin
				res_next = res_reg;
				if (i_mode) begin
					for (int k = 0; k < CTI_RES_BITS; k++) begin
						if (tap_rise[k]) begin
							res_next[k] = cell_y;
						end
					end
				end else if (shift_en) begin
					res_next = {res_reg[CTI_RES_BITS-2:0], cell_y};
				end
			end

			always_ff @(posedge i_clk or negedge rst_n) begin
				if (!rst_n) begin
					res_reg <= '0;
				end else begin
					res_reg <= res_next;
				end
			end

			assign instr_out[gi] = res_reg[CTI_RES_BITS-1];
		end
	endgenerate

	assign o_bidir_out = instr_out;
	assign o_bidir_oe  = 8'hFF;

	assign status_word = {15'h0000, i_mode, instr_out, o_direct};
endmodule // cti_top

// [cti_top_asserts.sv]
// Checker for the cell test top ports
`timescale 1ns/1ps
module cti_top_asserts (
	input wire logic       i_clk,
	input wire logic       i_resetn,
	input wire logic [2:0] i_stim,
	input wire logic       i_mode,
	input wire logic       i_trigger,
	input wire logic       i_avs_read,
	input wire logic       o_avs_waitrequest,
	input wire logic [7:0] o_direct,
	input wire logic [7:0] o_bidir_out,
	input wire logic [7:0] o_bidir_oe
);
	// ----
	// Properties
	// ----
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	sel_pair_a: assert property (o_direct[0] == !(i_stim[2] ? i_stim[1] : i_stim[0]))
		else $error("selector output wrong");
	maj_pair_a: assert property (o_direct[2] == ((i_stim[0] & i_stim[1]) | (i_stim[2] & (i_stim[0] | i_stim[1]))))
		else $error("majority output wrong");
	pair_match_a: assert property (o_direct[1] == o_direct[0] && o_direct[3] == o_direct[2])
		else $error("direct pair differs");
	latch_clear_a: assert property (!i_stim[2] ##1 !i_stim[2] |-> o_direct[5:4] == 2'h0)
		else $error("latch not cleared");
	flop_clear_a: assert property (!i_stim[2] |-> o_direct[7:6] == 2'h0)
		else $error("flop not cleared");
	oe_high_a: assert property (o_bidir_oe == 8'hFF)
		else $error("bidir not driven");
	read_wait_a: assert property ($rose(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
		else $error("read wait not one cycle");
	result_hold_a: assert property (!i_mode && !i_trigger [*3] |=> $stable(o_bidir_out))
		else $error("result moved without trigger");
	cover property ($rose(i_mode));
	cover property ($rose(i_avs_read));
	cover property (!i_stim[2] ##1 !i_stim[2]);
endmodule // cti_top_asserts

bind cti_top cti_top_asserts cti_top_asserts_inst (.*);

// [cti_top_tb.sv]
// Self-checking bench for the cell test top
`timescale 1ns/1ps
module cti_top_tb;
	import cti_pkg::*;
	logic        clk, resetn, rd, wr, mode, trig, lat, flp;
	logic [2:0]  stim, div, s, p;
	logic [3:0]  addr;
	logic [31:0] wd, rdata, r;
	logic        wreq;
	logic [7:0]  dir, bout, boe;
	logic [1:0]  c;
	logic [1:0]  q[$];
	int          err_count, checks, i, k, lo, hi;
	cti_top cti_top_inst (.i_clk(clk), .i_resetn(resetn), .i_stim(stim), .i_mode(mode), .i_trigger(trig),
		.i_div(div), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .o_direct(dir), .o_bidir_out(bout), .o_bidir_oe(boe));
	cti_tester cti_tester_inst (.i_clk(clk), .o_stim(stim), .o_mode(mode), .o_trigger(trig), .o_div(div));
	// ----
	// Model and tasks
	// ----
	function automatic logic [1:0] comb(input logic [2:0] x);
		return {(x[0] & x[1]) | (x[2] & (x[0] | x[1])), !(x[2] ? x[1] : x[0])};
	endfunction
	task automatic stop_test();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] v);
		int n;
		n = 0;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wd <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 20);
		if (wreq !== 1'b0) begin
			err_count++;
			stop_test();
		end else begin
			v = rdata;
			rd <= 1'b0;
			wr <= 1'b0;
		end
	endtask
	task automatic step(input logic [2:0] x);
		cti_tester_inst.setup(x, 1'b0, 3'h0);
		repeat (4) @(posedge clk);
		if (!x[2]) begin
			lat = 1'b0;
			flp = 1'b0;
		end else begin
			if (x[0]) lat = x[1];
			if (x[0] && !p[0]) flp = x[1];
		end
		p = x;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (90000) @(posedge clk);
		err_count++;
		stop_test();
	end
	// ----
	// Scenarios
	// ----
	initial begin
		{resetn, rd, wr, addr, wd, lat, flp, p} = '0;
		void'($urandom(32'h661f7b83));
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		for (i = 0; i < 40; i++) begin
			s = 3'($urandom);
			step({s[2:1], p[0]});
			step(s);
			c = comb(s);
			chk("direct", {24'h0, dir}, {24'h0, flp, flp, lat, lat, c[1], c[1], c[0], c[0]});
		end
		for (i = 0; i < 70; i++) begin
			s = 3'($urandom);
			cti_tester_inst.setup(s, 1'b0, 3'h0);
			cti_tester_inst.pulse(1);
			q.push_back(comb(s));
			if (q.size() >= 56) chk("pipeline", {30'h0, bout[2], bout[0]}, {30'h0, q.pop_front()});
			chk("pairs", {28'h0, bout[7], bout[5], bout[3], bout[1]}, {28'h0, bout[6], bout[4], bout[2], bout[0]});
		end
		// Preload one set, play its inverse: bit k shows which set the cell saw
		for (i = 0; i < 8; i++) begin
			s = 3'($urandom);
			c = comb(~s);
			cti_tester_inst.setup(s, 1'b0, 3'(i));
			repeat (12) cti_tester_inst.pulse(1);
			cti_tester_inst.setup(~s, 1'b1, 3'(i));
			cti_tester_inst.pulse(60);
			cti_tester_inst.setup(~s, 1'b0, 3'(i));
			for (k = 43; k >= 0; k--) begin
				lo = (k + 1) >> i;
				hi = (k + (1 << i)) >> i;
				if (hi < CTI_STIM_SETS) begin
					chk("capture", {30'h0, bout[2], bout[0]}, {30'h0, comb(s)});
				end else if (lo >= CTI_STIM_SETS) begin
					chk("capture", {30'h0, bout[2], bout[0]}, {30'h0, c});
				end
				cti_tester_inst.pulse(1);
			end
		end
		chk("oe", {24'h0, boe}, 32'h000000FF);
		bus(1'b0, CTI_IDX_CTRL, 32'h0, r);
		chk("ctrl reset", r, CTI_CTRL_RESET);
		bus(1'b1, CTI_IDX_STATUS, 32'hFFFFFFFF, r);
		bus(1'b0, CTI_IDX_STATUS, 32'h0, r);
		chk("status", {29'h0, r[CTI_ST_MODE], r[2], r[0]}, {29'h0, 1'b0, c});
		bus(1'b0, 4'h7, 32'h0, r);
		chk("unmapped", r, 32'h0);
		bus(1'b1, CTI_IDX_CTRL, 32'h0, r);
		bus(1'b0, CTI_IDX_CTRL, 32'h0, r);
		chk("ctrl write", r, 32'h0);
		bus(1'b1, CTI_IDX_CTRL, CTI_CTRL_RESET, r);
		bus(1'b0, CTI_IDX_CTRL, 32'h0, r);
		chk("ctrl restore", r, CTI_CTRL_RESET);
		stop_test();
	end
endmodule // cti_top_tb
